// ==== design/acc_params.svh ====
/*
 * Register offsets, field positions, reset values and timing counts
 * for the ADC conversion control block.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ACC_IDX_CONTROL    8'hD0
`define ACC_IDX_SETUP      8'hD1
`define ACC_IDX_IRQ        8'hD2
`define ACC_IDX_CHANNEL    8'hD3
`define ACC_IDX_THR_HI     8'hD4
`define ACC_IDX_THR_LO     8'hD5
`define ACC_IDX_RES_HI     8'hD6
`define ACC_IDX_RES_LO     8'hD7

// ****************************************************************
// Reset values
// ****************************************************************
`define ACC_RST_CONTROL    8'h80
`define ACC_RST_SETUP      8'h40
`define ACC_RST_IRQ        8'h00
`define ACC_RST_THR_HI     8'h80

// ****************************************************************
// Control register fields
// ****************************************************************
`define ACC_CTL_PD         7
`define ACC_CTL_ONESHOT    6
`define ACC_CTL_REPEAT     5
`define ACC_CTL_TICK       4
`define ACC_CTL_CMP        3
`define ACC_CTL_FILT       2
`define ACC_CTL_DIR        0

// ****************************************************************
// Setup and interrupt register fields
// ****************************************************************
`define ACC_SET_CLK_HI     7
`define ACC_SET_CLK_LO     6
`define ACC_SET_DUTY       5
`define ACC_SET_REF_HI     1
`define ACC_SET_REF_LO     0
`define ACC_IRQ_CMP_EN     7
`define ACC_IRQ_DONE_EN    6
`define ACC_IRQ_HIT        3
`define ACC_IRQ_DONE       2
`define ACC_IRQ_LIVE       1

// ****************************************************************
// Timing: conversion clock divisors and phase lengths
// ****************************************************************
`define ACC_DIV_00         12
`define ACC_DIV_01         24
`define ACC_DIV_10         96
`define ACC_DIV_11         384
`define ACC_SAMPLE_US      4
`define ACC_CONVERT_US     12
`define ACC_TOTAL_US       16
`define ACC_FAST_KHZ       1000
`define ACC_SAMPLE_TICKS   ((`ACC_SAMPLE_US * `ACC_FAST_KHZ) / 1000)
`define ACC_CONVERT_TICKS  ((`ACC_CONVERT_US * `ACC_FAST_KHZ) / 1000)
`define ACC_DUTY_US        32
`define ACC_WTICK_KHZ      32
`define ACC_DUTY_TICKS     ((`ACC_DUTY_US * `ACC_WTICK_KHZ + 999) / 1000)
`define ACC_FILT_NS        332
`define ACC_CLK_NS         100
`define ACC_FILT_CYCLES    ((`ACC_FILT_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)

`endif

// ==== design/acc_pkg.sv ====
/*
 * Types for the ADC conversion control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acc_pkg;

   // Conversion sequencer states
   typedef enum logic [1:0] {
      ACC_IDLE    = 2'b00,
      ACC_SAMPLE  = 2'b01,
      ACC_CONVERT = 2'b10
   } acc_state_e;

   // Reference rail choice sent to the analog core
   typedef enum logic [1:0] {
      ACC_REF_SUPPLY   = 2'b00,
      ACC_REF_EXTERNAL = 2'b01,
      ACC_REF_BANDGAP  = 2'b10
   } acc_ref_e;

   // Steering bundle sent to the analog core
   typedef struct packed {
      logic       power_on;
      logic       filter_on;
      logic       sample;
      logic       convert;
      logic [3:0] channel;
      acc_ref_e   reference;
   } acc_analog_s;

   // Watch-timer tick bundle
   typedef struct packed {
      logic event_tick;
      logic clock_tick;
   } acc_wtimer_s;

endpackage

// ==== design/acc_adc_ctrl.sv ====
/*
 * ADC conversion control: registers on APB, mode sequencing, clock
 * division, threshold compare and flags.
 * Assumes the analog core returns its 12-bit result and the live compare
 * level as synchronous inputs, and the watch timer gives one-cycle ticks.
 */
// Register access over APB was decided locally.
// Contract
// - At 1 MHz a conversion is 4 us sampling then 12 us converting.
// - Writing one-shot start with power on converts once; hardware clears it.
// - Completion updates result, sets done flag; interrupt only if enabled; the code sets no done flag in compare mode.
// - Repeat enable performs back-to-back conversions, each updating and flagging.
// - Compare mode flags hit when result above or below threshold per direction.
// - Threshold hit is a wake-up event.
// - Duty-cycled compare runs every 32 us from watch timer clock; the code rounds up to 2 watch clock ticks, about 62.5 us.
// - Each watch timer event in tick mode launches exactly one conversion; the code merges events that arrive before the pending launch starts into one.
// - Control bit 7 powers converter off; resets powered off.
// - Control bit 2 enables input filter; 332 ns settling needed.
// - Setup bits 7-6 divide clock by 12, 24, 96 or 384.
// - Setup bits 1-0 pick supply, external pin or bandgap reference.
// - Interrupt bits 7 and 6 enable compare and done interrupts.
// - Interrupt bit 3 shows compare hit.
// - Interrupt bit 2 shows conversion done.
// - Interrupt bit 1 shows live comparison.
// - Channel select field picks the converted input.
// - Reading the result clears hit and done flags.
// - Threshold and result are upper eight plus lower four bits.
`include "acc_params.svh"

module acc_adc_ctrl
   import acc_pkg::*;
#(
   parameter int DIV_W = 9
) (
   // Clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_NRST,
   // APB slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // Analog core
   input  wire logic [11:0] I_RESULT,
   input  wire logic        I_LIVE_ABOVE,
   output acc_analog_s      O_ANALOG,
   // Watch timer
   input  wire acc_wtimer_s I_WTIMER,
   // Event outputs
   output logic             O_IRQ,
   output logic             O_WAKE,
   output logic             O_FILTER_SETTLED
);

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   logic [7:0]      control;
   logic [7:0]      setup;
   logic [1:0]      irq_enable;
   logic [3:0]      channel;
   logic [11:0]     threshold;
   logic [11:0]     result;
   logic            threshold_hit_flag;
   logic            conversion_done_flag;
   acc_state_e      state;
   logic [DIV_W-1:0] div_count;
   logic [3:0]      phase_count;
   logic [5:0]      duty_count;
   logic [2:0]      filt_count;
   logic            duty_ok;
   logic            tick_pending;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   logic       wr_en;
   logic       rd_en;
   logic [9:0] idx;
   logic       mapped;
   logic       rd_result;

   assign idx       = I_PADDR[11:2];
   assign wr_en     = I_PSEL && I_PENABLE && I_PWRITE;
   assign rd_en     = I_PSEL && I_PENABLE && !I_PWRITE;
   assign mapped    = (idx >= {2'b00, 8'(`ACC_IDX_CONTROL)}) && (idx <= {2'b00, 8'(`ACC_IDX_RES_LO)});
   assign rd_result = rd_en && ((idx == 10'(`ACC_IDX_RES_HI)) || (idx == 10'(`ACC_IDX_RES_LO)));
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

   // ****************************************************************
   // Mode and control decode
   // ****************************************************************
   logic powered;
   logic cmp_mode;
   logic conv_tick;
   logic finish;
   logic start;
   logic cmp_hit;
   logic [DIV_W-1:0] div_last;

   assign powered  = !control[`ACC_CTL_PD];
   assign cmp_mode = control[`ACC_CTL_CMP];

   // Divisor chosen by the conversion clock field
   always_comb begin
      case (setup[`ACC_SET_CLK_HI:`ACC_SET_CLK_LO])
         2'b00:   div_last = DIV_W'(`ACC_DIV_00 - 1);
         2'b01:   div_last = DIV_W'(`ACC_DIV_01 - 1);
         2'b10:   div_last = DIV_W'(`ACC_DIV_10 - 1);
         default: div_last = DIV_W'(`ACC_DIV_11 - 1);
      endcase
   end

   // Conversion clock enable pulse
   always_ff @(posedge I_CLK) begin
      if (!I_NRST || state == ACC_IDLE) begin
         div_count <= '0;
      end else if (div_count >= div_last) begin
         div_count <= '0;
      end else begin
         div_count <= div_count + 1'b1;
      end
   end
   assign conv_tick = (state != ACC_IDLE) && (div_count >= div_last);

   // Duty-cycled compare gate, counted in watch timer clock ticks
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         duty_count <= '0;
         duty_ok    <= 1'b0;
      end else if (I_WTIMER.clock_tick) begin
         if (duty_count >= 6'(`ACC_DUTY_TICKS - 1)) begin
            duty_count <= '0;
            duty_ok    <= 1'b1;
         end else begin
            duty_count <= duty_count + 1'b1;
            duty_ok    <= duty_ok && !start;                       // Launch consumes the slot
         end
      end else if (start) begin
         duty_ok <= 1'b0;
      end
   end

   // Latch a watch timer event until it is launched
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         tick_pending <= 1'b0;
      end else if (!control[`ACC_CTL_TICK] || !powered) begin
         tick_pending <= 1'b0;
      end else if (I_WTIMER.event_tick) begin
         tick_pending <= 1'b1;
      end else if (start) begin
         tick_pending <= 1'b0;
      end
   end

   // Start conditions for each mode
   always_comb begin
      start = 1'b0;
      if (powered && state == ACC_IDLE) begin
         if (control[`ACC_CTL_ONESHOT]) begin
            start = 1'b1;
         end else if (control[`ACC_CTL_REPEAT]) begin
            start = 1'b1;
         end else if (control[`ACC_CTL_TICK]) begin
            start = tick_pending;
         end else if (cmp_mode) begin
            start = !setup[`ACC_SET_DUTY] || duty_ok;
         end
      end
   end

   // ****************************************************************
   // Conversion sequencer
   // ****************************************************************
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         state       <= ACC_IDLE;
         phase_count <= '0;
      end else if (!powered) begin
         state       <= ACC_IDLE;
         phase_count <= '0;
      end else begin
         case (state)
            ACC_IDLE: begin
               if (start) begin
                  state       <= ACC_SAMPLE;
                  phase_count <= '0;
               end
            end
            ACC_SAMPLE: begin
               if (conv_tick) begin
                  if (phase_count == 4'(`ACC_SAMPLE_TICKS - 1)) begin
                     state       <= ACC_CONVERT;
                     phase_count <= '0;
                  end else begin
                     phase_count <= phase_count + 1'b1;
                  end
               end
            end
            ACC_CONVERT: begin
               if (conv_tick) begin
                  if (phase_count == 4'(`ACC_CONVERT_TICKS - 1)) begin
                     state       <= ACC_IDLE;
                     phase_count <= '0;
                  end else begin
                     phase_count <= phase_count + 1'b1;
                  end
               end
            end
            default: begin
               state       <= ACC_IDLE;
               phase_count <= '0;
            end
         endcase
      end
   end
   assign finish = powered && state == ACC_CONVERT && conv_tick
                   && phase_count == 4'(`ACC_CONVERT_TICKS - 1);

   // ****************************************************************
   // Result and flags
   // ****************************************************************
   assign cmp_hit = control[`ACC_CTL_DIR] ? (I_RESULT < threshold)
                                          : (I_RESULT > threshold);

   // Result capture at completion
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         result <= '0;
      end else if (finish) begin
         result <= I_RESULT;
      end
   end

   // Done flag; a completion in the read cycle wins over the clear
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         conversion_done_flag <= 1'b0;
      end else if (finish && !cmp_mode) begin
         conversion_done_flag <= 1'b1;
      end else if (rd_result) begin
         conversion_done_flag <= 1'b0;
      end
   end

   // Compare hit flag; set wins over clear
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         threshold_hit_flag <= 1'b0;
      end else if (finish && cmp_mode && cmp_hit) begin
         threshold_hit_flag <= 1'b1;
      end else if (rd_result) begin
         threshold_hit_flag <= 1'b0;
      end
   end

   // Filter settling count after the filter is enabled
   always_ff @(posedge I_CLK) begin
      if (!I_NRST || !control[`ACC_CTL_FILT]) begin
         filt_count <= '0;
      end else if (filt_count != 3'(`ACC_FILT_CYCLES)) begin
         filt_count <= filt_count + 1'b1;
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         control <= `ACC_RST_CONTROL;
      end else if (wr_en && idx == 10'(`ACC_IDX_CONTROL)) begin
         control <= I_PWDATA[7:0] & 8'hFD;
      end else if (finish || !powered) begin
         control[`ACC_CTL_ONESHOT] <= 1'b0;
      end
   end

   // Setup, interrupt enables, channel and threshold
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         setup      <= `ACC_RST_SETUP;
         irq_enable <= 2'h0;
         channel    <= 4'h0;
         threshold  <= {`ACC_RST_THR_HI, 4'h0};
      end else if (wr_en) begin
         case (idx)
            10'(`ACC_IDX_SETUP):   setup      <= I_PWDATA[7:0] & 8'hE3;
            10'(`ACC_IDX_IRQ):     irq_enable <= I_PWDATA[7:6];
            10'(`ACC_IDX_CHANNEL): channel    <= I_PWDATA[3:0];
            10'(`ACC_IDX_THR_HI):  threshold[11:4] <= I_PWDATA[7:0];
            10'(`ACC_IDX_THR_LO):  threshold[3:0]  <= I_PWDATA[3:0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   always_comb begin
      O_PRDATA = 32'h0000_0000;
      if (rd_en) begin
         case (idx)
            10'(`ACC_IDX_CONTROL): O_PRDATA[7:0] = control;
            10'(`ACC_IDX_SETUP):   O_PRDATA[7:0] = setup;
            10'(`ACC_IDX_IRQ):     O_PRDATA[7:0] = {irq_enable, 2'b00, threshold_hit_flag,
                                                    conversion_done_flag, I_LIVE_ABOVE && powered, 1'b0};
            10'(`ACC_IDX_CHANNEL): O_PRDATA[3:0] = channel;
            10'(`ACC_IDX_THR_HI):  O_PRDATA[7:0] = threshold[11:4];
            10'(`ACC_IDX_THR_LO):  O_PRDATA[3:0] = threshold[3:0];
            10'(`ACC_IDX_RES_HI):  O_PRDATA[7:0] = result[11:4];
            10'(`ACC_IDX_RES_LO):  O_PRDATA[3:0] = result[3:0];
            default:               O_PRDATA = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // Outputs to the analog core and system
   // ****************************************************************
   always_comb begin
      O_ANALOG.power_on  = powered;
      O_ANALOG.filter_on = control[`ACC_CTL_FILT];
      O_ANALOG.sample    = state == ACC_SAMPLE;
      O_ANALOG.convert   = state == ACC_CONVERT;
      O_ANALOG.channel   = channel;
      O_ANALOG.reference = setup[`ACC_SET_REF_HI] ? ACC_REF_BANDGAP
                         : (setup[`ACC_SET_REF_LO] ? ACC_REF_EXTERNAL : ACC_REF_SUPPLY);
   end

   assign O_IRQ = (conversion_done_flag && irq_enable[0])
                || (threshold_hit_flag && irq_enable[1]);
   assign O_WAKE = threshold_hit_flag;
   assign O_FILTER_SETTLED = filt_count == 3'(`ACC_FILT_CYCLES);

endmodule

// ==== verif/acc_adc_ctrl_sva.sv ====
/* Port checker for acc_adc_ctrl.
   Assumes it is bound to the top module and sees its ports only. */
module acc_adc_ctrl_sva
   import acc_pkg::*;
(
   input wire logic        I_CLK,
   input wire logic        I_NRST,
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] O_PRDATA,
   input wire logic        O_PREADY,
   input wire logic        O_PSLVERR,
   input wire acc_analog_s O_ANALOG,
   input wire logic        O_FILTER_SETTLED
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);
   logic        acc;
   logic        unmapped;
   logic        sp_d;
   logic        cv_d;
   logic [15:0] cnt_sp;
   logic [15:0] cnt_cv;
   // Access phase and decode
   assign acc      = I_PSEL && I_PENABLE;
   assign unmapped = (I_PADDR[11:2] < 10'h0D0) || (I_PADDR[11:2] > 10'h0D7);
   // Length of the latest sampling and converting phases
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         {sp_d, cv_d, cnt_sp, cnt_cv} <= '0;
      end else begin
         sp_d <= O_ANALOG.sample;
         cv_d <= O_ANALOG.convert;
         if (O_ANALOG.sample) cnt_sp <= sp_d ? cnt_sp + 16'h1 : 16'h1;
         if (O_ANALOG.convert) cnt_cv <= cv_d ? cnt_cv + 16'h1 : 16'h1;
      end
   end
   sequence s_sample_end; $fell(O_ANALOG.sample) && O_ANALOG.power_on; endsequence
   sequence s_conv_end; $fell(O_ANALOG.convert) && O_ANALOG.power_on; endsequence
   sequence s_off; !O_ANALOG.power_on ##1 !O_ANALOG.power_on; endsequence
   property p_ready; acc |-> O_PREADY; endproperty
   property p_refuse; acc && unmapped |-> O_PSLVERR && O_PRDATA == 32'h0; endproperty
   property p_mapped; acc && !unmapped |-> !O_PSLVERR && O_PRDATA[31:8] == 24'h0; endproperty
   property p_idle; !acc |-> O_PRDATA == 32'h0; endproperty
   property p_sample_len; s_sample_end |-> cnt_sp inside {16'h30, 16'h60, 16'h180, 16'h600}; endproperty
   property p_order; s_sample_end |-> O_ANALOG.convert; endproperty
   property p_ratio; s_conv_end |-> cnt_cv == cnt_sp * 16'h3; endproperty
   property p_off; s_off |-> !O_ANALOG.sample && !O_ANALOG.convert; endproperty
   property p_filt; $rose(O_ANALOG.filter_on) |-> !O_FILTER_SETTLED [*3] ##[1:3] O_FILTER_SETTLED; endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
   a_mapped: assert property (p_mapped) else $error("mapped access wrong");
   a_idle: assert property (p_idle) else $error("read data outside access");
   a_sample_len: assert property (p_sample_len) else $error("sampling length wrong");
   a_order: assert property (p_order) else $error("convert does not follow sample");
   a_ratio: assert property (p_ratio) else $error("convert not three times sample");
   a_off: assert property (p_off) else $error("activity while powered off");
   a_filt: assert property (p_filt) else $error("filter settle time wrong");
endmodule

bind acc_adc_ctrl acc_adc_ctrl_sva acc_adc_ctrl_sva_i (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
   .O_PSLVERR(O_PSLVERR), .O_ANALOG(O_ANALOG), .O_FILTER_SETTLED(O_FILTER_SETTLED));

// ==== verif/acc_analog_model.sv ====
/* Stand-in for the analog core and the watch timer.
   Assumes the same clock as the control block and a 10 MHz rate. */
module acc_analog_model
   import acc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire acc_analog_s i_analog,
   input  wire logic        i_fire,
   output logic [11:0]      o_result,
   output logic             o_live_above,
   output acc_wtimer_s      o_wtimer
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] div = 9'h000;
   // Result valid while converting, inverted otherwise
   assign o_result     = i_analog.convert ? {i_analog.channel, 8'h3C} : ~{i_analog.channel, 8'h3C};
   assign o_live_above = i_analog.power_on & i_analog.channel[0];
   // Free watch clock near 32 kHz, event tick on request
   always_ff @(posedge i_clk) div <= (div == 9'h137) ? 9'h000 : div + 9'h001;
   assign o_wtimer = {i_fire, div == 9'h137};
endmodule

// ==== verif/adc_conversion_control_tb_top.sv ====
/* Testbench for acc_adc_ctrl with analog model.
   Assumes the checker is bound to the design by its own file. */
module adc_conversion_control_tb_top;
   import acc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, live, irq, wake, settled, fire, err;
   logic [11:0] paddr;
   logic [11:0] result;
   logic [31:0] pwdata, prdata;
   logic [7:0]  rv;
   acc_analog_s analog;
   acc_wtimer_s wtimer;
   int fail_count = 0;
   int tests_run = 0;
   int dv[4] = '{12, 24, 96, 384};
   logic [7:0] rst_v[8] = '{8'h80, 8'h40, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
   acc_adc_ctrl acc_adc_ctrl_i (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_RESULT(result), .I_LIVE_ABOVE(live), .O_ANALOG(analog),
      .I_WTIMER(wtimer), .O_IRQ(irq), .O_WAKE(wake), .O_FILTER_SETTLED(settled));
   acc_analog_model acc_analog_model_i (.i_clk(clk), .i_analog(analog), .i_fire(fire),
      .o_result(result), .o_live_above(live), .o_wtimer(wtimer));
   // ****************************************************************
   // Bus, compare and closing tasks
   // ****************************************************************
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      psel <= 1'b1; pwrite <= wr; paddr <= {2'b00, idx, 2'b00}; pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      // Access phase holds until ready; only the watchdog ends a hung wait
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin fail_count++; $display("MISMATCH %0t: got %h want %h", $time, g, e); end
   endtask
   task automatic chk1(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin fail_count++; $display("MISMATCH %0t: flag %b want %b", $time, g, e); end
   endtask
   task automatic wait_ev(input logic on_wake, input int lim, output int n);
      n = 0;
      while (((on_wake ? wake : irq) !== 1'b1) && n < lim) begin @(posedge clk); n++; end
   endtask
   task automatic conclude();
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Clock, 100 ns period
   initial begin clk = 1'b0; forever #50 clk = ~clk; end
   // Watchdog
   initial begin repeat (40000) @(posedge clk); fail_count++; conclude(); end
   // Main sequence
   initial begin
      int n;
      {psel, penable, pwrite, fire, nrst} = '0; paddr = '0; pwdata = '0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin apb(0, 8'(8'hD0 + i), 0, rv); chk8(rv, rst_v[i]); end
      apb(1, 8'hD8, 8'h55, rv); chk1(err, 1'b1);
      apb(0, 8'hD8, 0, rv); chk8(rv, 8'h00);
      apb(1, 8'hD0, 8'h82, rv); apb(0, 8'hD0, 0, rv); chk8(rv, 8'h80);
      for (int r = 0; r < 4; r++) begin
         apb(1, 8'hD1, {r[1] ? 2'b11 : 2'b00, 4'h7, 2'(r)}, rv);
         apb(0, 8'hD1, 0, rv); chk8(rv, {r[1] ? 2'b11 : 2'b00, 4'h0, 2'(r)});
         chk8({6'h0, analog.reference}, {6'h0, r[1] ? ACC_REF_BANDGAP : acc_ref_e'(2'(r))});
      end
      apb(1, 8'hD2, 8'h40, rv);
      for (int c = 0; c < 4; c++) begin
         apb(1, 8'hD1, {2'(c), 6'h00}, rv);
         apb(1, 8'hD3, 8'(c + 5), rv);
         apb(1, 8'hD0, 8'h40, rv);
         wait_ev(0, 7000, n);
         chk1(n inside {[16 * dv[c] - 4 : 16 * dv[c] + 2]}, 1'b1);
         chk8({4'h0, analog.channel}, 8'(c + 5));
         apb(0, 8'hD0, 0, rv); chk8(rv, 8'h00);
         apb(0, 8'hD2, 0, rv); chk8(rv, {6'h11, ~c[0], 1'b0});
         apb(0, 8'hD6, 0, rv); chk8(rv, {4'(c + 5), 4'h3});
         apb(0, 8'hD7, 0, rv); chk8(rv, 8'h0C);
         apb(0, 8'hD2, 0, rv); chk8(rv, {6'h10, ~c[0], 1'b0}); chk1(irq, 1'b0);
      end
      apb(1, 8'hD2, 8'h00, rv); apb(1, 8'hD1, 8'h00, rv); apb(1, 8'hD0, 8'h40, rv);
      repeat (260) @(posedge clk);
      chk1(irq, 1'b0); apb(0, 8'hD2, 0, rv); chk8(rv, 8'h04);
      apb(0, 8'hD6, 0, rv); apb(1, 8'hD2, 8'h40, rv); apb(1, 8'hD0, 8'h20, rv);
      for (int k = 0; k < 2; k++) begin
         wait_ev(0, 400, n); chk1(irq, 1'b1);
         apb(0, 8'hD6, 0, rv); chk8(rv, 8'h83);
      end
      repeat (50) @(posedge clk);
      apb(1, 8'hD0, 8'h80, rv); repeat (300) @(posedge clk);
      chk1(analog.power_on, 1'b0);
      apb(0, 8'hD2, 0, rv); chk8(rv, 8'h40);
      apb(1, 8'hD3, 8'h05, rv); apb(1, 8'hD4, 8'h50, rv); apb(1, 8'hD5, 8'h00, rv);
      apb(1, 8'hD2, 8'h80, rv); apb(1, 8'hD0, 8'h08, rv);
      chk1(analog.power_on, 1'b1);
      wait_ev(1, 400, n); chk1(wake, 1'b1); chk1(irq, 1'b1);
      apb(0, 8'hD2, 0, rv); chk8(rv, 8'h8A);
      apb(0, 8'hD6, 0, rv); chk8(rv, 8'h53); chk1(wake, 1'b0);
      apb(1, 8'hD0, 8'h09, rv); repeat (500) @(posedge clk); chk1(wake, 1'b0);
      // Abort the free-running compare first; the first two duty hits may sit off the slot grid
      apb(1, 8'hD0, 8'h80, rv); apb(1, 8'hD1, 8'h20, rv); apb(1, 8'hD0, 8'h08, rv);
      for (int k = 0; k < 2; k++) begin wait_ev(1, 1500, n); apb(0, 8'hD6, 0, rv); end
      wait_ev(1, 1500, n); chk1(wake, 1'b1); chk1(n inside {[400:630]}, 1'b1);
      apb(1, 8'hD0, 8'h80, rv); apb(1, 8'hD2, 8'h40, rv); apb(0, 8'hD6, 0, rv);
      apb(1, 8'hD0, 8'h10, rv); repeat (400) @(posedge clk); chk1(irq, 1'b0);
      fire <= 1'b1; @(posedge clk); fire <= 1'b0;
      wait_ev(0, 400, n); chk1(irq, 1'b1); apb(0, 8'hD6, 0, rv);
      repeat (500) @(posedge clk); chk1(irq, 1'b0);
      apb(1, 8'hD0, 8'h84, rv); repeat (6) @(posedge clk);
      chk1(analog.filter_on, 1'b1); chk1(settled, 1'b1);
      conclude();
   end
endmodule
